//--- logic/itcsp_top.sv
// Design decision made here: the APB interface to the registers.
`default_nettype none
// Behaviour
// [R1] The main source selector stops counting at 000 and picks one of five sources for 001 to 101.
// [R2] The capture source selector in bits 6 to 4 uses the same codes to drive the capture count clock.
// [R3] Bits 3 and 7 of the select and divider registers read as zero and software writes zero there.
// [R4] Software changes both source selectors only while all four count enables are zero.
// [R5] Divider field a clocks counter a, the pair a and b, or all four counters by chaining mode.
// [R6] Divider field b clocks counter b only in 8-bit mode and is left at zero otherwise.
// [R7] Software writes divider field a only while count enable a is zero.
// [R8] In 8-bit mode software writes divider field b only while count enable b is zero.
// [R9] Divider field d in bits 6 to 4 of the high register clocks counter d in 8-bit mode.
// [R10] In 8-bit or 16-bit mode software writes divider field c only while count enable c is zero.
// [R11] In 8-bit mode software writes divider field d only while count enable d is zero.
// [R12] Divider field c clocks counter c, or the pair c and d in 16-bit mode, and is unused in 32-bit mode.
// [R13] The chaining mode picks four 8-bit, two 16-bit or one 32-bit counter, and code 11 is prohibited.
// [R14] A set enable starts its counter and a cleared one stops and clears it at once.
// [R15] Every divider field divides the main count clock by two to the power of its code.
module itcsp_top (
    input wire logic clk,
    input wire logic rst,
    input wire itcsp_pkg::itcsp_apb_req_type apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire itcsp_pkg::itcsp_src_type src_pins,
    output logic main_count_clock,
    output logic capture_count_clock,
    output logic [3:0] counter_tick,
    output logic [3:0] counter_clear
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [2:0] main_clock_source_sel_q;
    logic [2:0] capture_clock_source_sel_q;
    logic [2:0] divider_field_a_q;
    logic [2:0] divider_field_b_q;
    logic [2:0] divider_field_c_q;
    logic [2:0] divider_field_d_q;
    logic [3:0] count_enable_q;
    logic [1:0] chaining_mode_q;
    logic [31:0] prdata_q;
    logic [6:0] presc_q;
    logic [3:0] chan_en;
    logic [2:0] chan_code [4];
    logic [3:0] tick_q;
    logic [3:0] clear_q;
    logic main_tick_q;
    logic cap_tick_q;
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic [4:0] sync3_q;
    logic [4:0] src_rise;
    logic [7:0] reg_idx;
    logic setup_phase;
    logic wr_strobe;
    logic addr_hit;
    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    assign reg_idx = apb_req.paddr[9:2];
    assign setup_phase = apb_req.psel && !apb_req.penable;
    assign addr_hit = (apb_req.paddr[11:10] == 2'h0) && (apb_req.paddr[1:0] == 2'h0) &&
        (reg_idx == itcsp_pkg::CTRL_IDX || reg_idx == itcsp_pkg::CSEL_IDX ||
         reg_idx == itcsp_pkg::DIVL_IDX || reg_idx == itcsp_pkg::DIVH_IDX ||
         reg_idx == itcsp_pkg::STAT_IDX);
    assign wr_strobe = apb_req.psel && apb_req.penable && apb_req.pwrite && addr_hit;
    assign pready = apb_req.psel && apb_req.penable;
    assign pslverr = apb_req.psel && apb_req.penable && !addr_hit;
    assign prdata = prdata_q;

    // Read data is captured in the setup cycle so that it comes from a flop.
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_q <= 32'h0;
        end else if (setup_phase && !apb_req.pwrite) begin
            prdata_q <= 32'h0;
            case (reg_idx)
                itcsp_pkg::CTRL_IDX: begin
                    prdata_q[itcsp_pkg::EN_LSB +: 4] <= count_enable_q;
                    prdata_q[itcsp_pkg::MODE_LSB +: 2] <= chaining_mode_q;
                end
                itcsp_pkg::CSEL_IDX: begin
                    prdata_q[itcsp_pkg::LO_LSB +: 3] <= main_clock_source_sel_q; // [R3]
                    prdata_q[itcsp_pkg::HI_LSB +: 3] <= capture_clock_source_sel_q;
                end
                itcsp_pkg::DIVL_IDX: begin
                    prdata_q[itcsp_pkg::LO_LSB +: 3] <= divider_field_a_q; // [R3]
                    prdata_q[itcsp_pkg::HI_LSB +: 3] <= divider_field_b_q;
                end
                itcsp_pkg::DIVH_IDX: begin
                    prdata_q[itcsp_pkg::LO_LSB +: 3] <= divider_field_c_q; // [R3]
                    prdata_q[itcsp_pkg::HI_LSB +: 3] <= divider_field_d_q;
                end
                itcsp_pkg::STAT_IDX: begin
                    prdata_q[0 +: itcsp_pkg::PRESC_W] <= presc_q;
                    prdata_q[itcsp_pkg::STAT_EN_LSB +: 4] <= chan_en;
                end
                default: begin
                    prdata_q <= 32'h0;
                end
            endcase
        end
    end

    // Writes are taken as stored; the interlocks against the enables are software's duty.
    always_ff @(posedge clk) begin
        if (rst) begin
            main_clock_source_sel_q <= itcsp_pkg::FIELD_RST;
            capture_clock_source_sel_q <= itcsp_pkg::FIELD_RST;
        end else if (wr_strobe && reg_idx == itcsp_pkg::CSEL_IDX) begin
            main_clock_source_sel_q <= apb_req.pwdata[itcsp_pkg::LO_LSB +: 3];
            capture_clock_source_sel_q <= apb_req.pwdata[itcsp_pkg::HI_LSB +: 3];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            divider_field_a_q <= itcsp_pkg::FIELD_RST;
            divider_field_b_q <= itcsp_pkg::FIELD_RST;
        end else if (wr_strobe && reg_idx == itcsp_pkg::DIVL_IDX) begin
            divider_field_a_q <= apb_req.pwdata[itcsp_pkg::LO_LSB +: 3];
            divider_field_b_q <= apb_req.pwdata[itcsp_pkg::HI_LSB +: 3];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            divider_field_c_q <= itcsp_pkg::FIELD_RST;
            divider_field_d_q <= itcsp_pkg::FIELD_RST;
        end else if (wr_strobe && reg_idx == itcsp_pkg::DIVH_IDX) begin
            divider_field_c_q <= apb_req.pwdata[itcsp_pkg::LO_LSB +: 3];
            divider_field_d_q <= apb_req.pwdata[itcsp_pkg::HI_LSB +: 3];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_enable_q <= itcsp_pkg::EN_RST;
            chaining_mode_q <= itcsp_pkg::MODE_RST;
        end else if (wr_strobe && reg_idx == itcsp_pkg::CTRL_IDX) begin
            count_enable_q <= apb_req.pwdata[itcsp_pkg::EN_LSB +: 4];
            chaining_mode_q <= apb_req.pwdata[itcsp_pkg::MODE_LSB +: 2];
        end
    end

    // ----------------------------------------------------------------
    // Source synchronisers and source selection
    // ----------------------------------------------------------------
    // Sources are sampled, so each must stay below a quarter of clk to be seen.
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
            sync3_q <= 5'h00;
        end else begin
            sync1_q <= src_pins;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end
    assign src_rise = sync2_q & ~sync3_q;

    function automatic logic pick_src(input logic [2:0] sel, input logic [4:0] rise);
        logic hit;
        hit = 1'b0;
        if (sel != itcsp_pkg::SRC_STOP && sel <= itcsp_pkg::SRC_LAST) begin
            hit = rise[3'(sel - 3'h1)];
        end
        return hit;
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            main_tick_q <= 1'b0;
            cap_tick_q <= 1'b0;
        end else begin
            main_tick_q <= pick_src(main_clock_source_sel_q, src_rise); // [R1]
            cap_tick_q <= pick_src(capture_clock_source_sel_q, src_rise); // [R2]
        end
    end
    assign main_count_clock = main_tick_q;
    assign capture_count_clock = cap_tick_q;

    // ----------------------------------------------------------------
    // Channel routing by chaining mode
    // ----------------------------------------------------------------
    always_comb begin
        chan_code[0] = divider_field_a_q; // [R5]
        chan_code[1] = divider_field_a_q;
        chan_code[2] = divider_field_a_q;
        chan_code[3] = divider_field_a_q;
        chan_en = 4'h0;
        case (chaining_mode_q) // [R13]
            itcsp_pkg::MODE_8: begin
                chan_code[1] = divider_field_b_q; // [R6]
                chan_code[2] = divider_field_c_q; // [R12]
                chan_code[3] = divider_field_d_q; // [R9]
                chan_en = count_enable_q;
            end
            itcsp_pkg::MODE_16: begin
                chan_code[2] = divider_field_c_q; // [R12]
                chan_code[3] = divider_field_c_q;
                chan_en = {{2{count_enable_q[2]}}, {2{count_enable_q[0]}}};
            end
            itcsp_pkg::MODE_32: begin
                chan_en = {4{count_enable_q[0]}};
            end
            default: begin
                chan_en = 4'h0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Prescaler and divided ticks
    // ----------------------------------------------------------------
    // The ladder restarts while no channel runs, so the first divided tick has a fixed delay.
    always_ff @(posedge clk) begin
        if (rst || chan_en == 4'h0) begin
            presc_q <= itcsp_pkg::PRESC_RST;
        end else if (main_tick_q) begin
            presc_q <= presc_q + 7'h01;
        end
    end

    function automatic logic div_hit(input logic [2:0] code, input logic [6:0] presc);
        logic [6:0] mask;
        mask = 7'((8'h01 << code) - 8'h01);
        return (presc & mask) == mask;
    endfunction

    generate
        for (genvar ch = 0; ch < 4; ch++) begin : g_chan
            always_ff @(posedge clk) begin
                if (rst) begin
                    tick_q[ch] <= 1'b0;
                    clear_q[ch] <= 1'b1;
                end else begin
                    tick_q[ch] <= chan_en[ch] && main_tick_q && div_hit(chan_code[ch], presc_q); // [R15]
                    clear_q[ch] <= !chan_en[ch]; // [R14]
                end
            end
        end
    endgenerate
    assign counter_tick = tick_q;
    assign counter_clear = clear_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_ctrl_write;
        wr_strobe && reg_idx == itcsp_pkg::CTRL_IDX;
    endsequence

    sequence s_clear_a_in_8;
        s_ctrl_write ##0 !apb_req.pwdata[0] && apb_req.pwdata[7:6] == itcsp_pkg::MODE_8;
    endsequence

    a_main_stop_quiet: assert property ( // [R1]
        main_clock_source_sel_q == itcsp_pkg::SRC_STOP ##1 main_clock_source_sel_q == itcsp_pkg::SRC_STOP
        |-> !main_count_clock)
        else $error("main clock ticked while stopped");

    a_capture_follows_src: assert property ( // [R2]
        capture_clock_source_sel_q == 3'h1 && src_rise[0] && !wr_strobe |=> capture_count_clock)
        else $error("capture clock missed its source edge");

    a_reserved_read_zero: assert property ( // [R3]
        setup_phase && !apb_req.pwrite &&
        (reg_idx == itcsp_pkg::CSEL_IDX || reg_idx == itcsp_pkg::DIVL_IDX || reg_idx == itcsp_pkg::DIVH_IDX)
        |=> prdata[7] == 1'b0 && prdata[3] == 1'b0)
        else $error("reserved bits read nonzero");

    a_div_a_ratio: assert property ( // [R5]
        counter_tick[0] |-> $past(main_tick_q) && div_hit($past(divider_field_a_q), $past(presc_q)))
        else $error("counter a tick off the ladder");

    a_pair_ab_tied: assert property ( // [R6]
        chaining_mode_q != itcsp_pkg::MODE_8 && $stable(chaining_mode_q) |-> counter_tick[1] == counter_tick[0])
        else $error("counter b not clocked with a when chained");

    a_div_d_by_two: assert property ( // [R9]
        counter_tick[3] && $past(chaining_mode_q) == itcsp_pkg::MODE_8 && $past(divider_field_d_q) == 3'h1
        |-> $past(chan_en[3]) && $past(presc_q[0]))
        else $error("field d divide by two wrong");

    a_pair_cd_tied: assert property ( // [R12]
        chaining_mode_q == itcsp_pkg::MODE_16 && $stable(chaining_mode_q) |-> counter_tick[3] == counter_tick[2])
        else $error("counter d not clocked with c in 16-bit mode");

    a_mode_bad_idle: assert property ( // [R13]
        chaining_mode_q == 2'h3 ##1 chaining_mode_q == 2'h3 |-> counter_tick == 4'h0 && counter_clear == 4'hF)
        else $error("prohibited mode let a counter run");

    a_clear_at_once: assert property ( // [R14]
        s_clear_a_in_8 |=> ##1 counter_clear[0] && !counter_tick[0])
        else $error("counter a not cleared after disable");

    a_ladder_by_128: assert property ( // [R15]
        counter_tick[0] && divider_field_a_q == 3'h7 && $stable(divider_field_a_q) |-> $past(presc_q) == 7'h7F)
        else $error("divide by 128 fired early");
endmodule
`default_nettype wire

//--- logic/itcsp_pkg.sv
`default_nettype none
package itcsp_pkg;
    // ----------------------------------------------------------------
    // Register indices, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_IDX = 8'h06;
    localparam logic [7:0] CSEL_IDX = 8'h07;
    localparam logic [7:0] DIVL_IDX = 8'h08;
    localparam logic [7:0] DIVH_IDX = 8'h09;
    localparam logic [7:0] STAT_IDX = 8'h10;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int FIELD_W = 3;
    localparam int LO_LSB = 0;
    localparam int HI_LSB = 4;
    localparam int EN_LSB = 0;
    localparam int MODE_LSB = 6;
    localparam int STAT_EN_LSB = 8;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] FIELD_RST = 3'h0;
    localparam logic [3:0] EN_RST = 4'h0;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [6:0] PRESC_RST = 7'h00;
    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_8 = 2'h0;
    localparam logic [1:0] MODE_16 = 2'h1;
    localparam logic [1:0] MODE_32 = 2'h2;
    localparam logic [2:0] SRC_STOP = 3'h0;
    localparam logic [2:0] SRC_LAST = 3'h5;
    localparam int NUM_SRC = 5;
    localparam int PRESC_W = 7;
    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } itcsp_apb_req_type;
    typedef struct packed {
        logic event_link_input;
        logic subsystem_clock;
        logic main_external_osc;
        logic medium_internal_osc;
        logic fast_internal_osc;
    } itcsp_src_type;
endpackage
`default_nettype wire

//--- sim/itcsp_bench.sv
`default_nettype none
module interval_timer_clock_select_prescale_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // Stimulus and observation
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    itcsp_pkg::itcsp_apb_req_type req = '0;
    itcsp_pkg::itcsp_src_type src = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic mclk;
    logic cclk;
    logic [3:0] tick;
    logic [3:0] clr;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    int n_main = 0;
    int n_cap = 0;
    int n_tick [4] = '{0, 0, 0, 0};

    always #10 clk = ~clk;

    itcsp_top dut (
        .clk(clk),
        .rst(rst),
        .apb_req(req),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .src_pins(src),
        .main_count_clock(mclk),
        .capture_count_clock(cclk),
        .counter_tick(tick),
        .counter_clear(clr)
    );

    // Pulses are counted here so that a tick that lands between two checks is never lost.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (mclk === 1'b1) n_main <= n_main + 1;
        if (cclk === 1'b1) n_cap <= n_cap + 1;
        for (int i = 0; i < 4; i++) begin
            if (tick[i] === 1'b1) n_tick[i] <= n_tick[i] + 1;
        end
        if (cyc == 40000) begin
            err_total++;
            $display("ERROR t=%0t timeout", $time);
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        checks++;
        if (got != exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= {2'b00, idx, 2'b00};
        req.pwdata <= wd;
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wreg(input logic [7:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd, rd, er);
    endtask

    // Each level is held three cycles, above the two-cycle minimum of the synchroniser.
    task automatic pulse(input int k);
        @(posedge clk);
        src <= itcsp_pkg::itcsp_src_type'(5'h01 << k);
        repeat (3) @(posedge clk);
        src <= '0;
        repeat (2) @(posedge clk);
    endtask

    // Fields f and expected effective codes g are packed d,c,b,a from the top.
    task automatic ladder(input logic [1:0] md, input logic [3:0] en, input logic [11:0] f, input logic [11:0] g);
        int t0 [4];
        wreg(itcsp_pkg::CTRL_IDX, 32'h0);
        wreg(itcsp_pkg::DIVL_IDX, {24'h0, 1'b0, f[5:3], 1'b0, f[2:0]});
        wreg(itcsp_pkg::DIVH_IDX, {24'h0, 1'b0, f[11:9], 1'b0, f[8:6]});
        wreg(itcsp_pkg::CTRL_IDX, {24'h0, md, 2'b00, en});
        t0 = n_tick;
        repeat (128) pulse(0);
        repeat (8) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            chk_cnt(n_tick[i] - t0[i], 128 >> g[3*i+:3]);
        end
        chk_reg({28'h0, clr}, 32'h0);
        wreg(itcsp_pkg::CTRL_IDX, 32'h0);
        repeat (3) @(posedge clk);
        chk_reg({28'h0, clr}, 32'hF);
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, itcsp_pkg::DIVL_IDX, 32'h0, rd, er);
        chk_reg(rd, 32'h0);
        apb(1'b0, itcsp_pkg::DIVH_IDX, 32'h0, rd, er);
        chk_reg(rd, 32'h0);
        // Reserved bits are written as zero, as software must; the design side asserts they read back zero.
        for (int i = 7; i <= 9; i++) begin
            wreg(8'(i), 32'h00000077);
            apb(1'b0, 8'(i), 32'h0, rd, er);
            chk_reg(rd, 32'h77);
            wreg(8'(i), 32'h0);
        end
        apb(1'b0, 8'h3F, 32'h0, rd, er);
        chk_reg({31'h0, er}, 32'h1);
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            wreg(itcsp_pkg::CSEL_IDX, {25'h0, 3'(7 - c), 1'b0, 3'(c)});
            for (int k = 0; k < 5; k++) begin
                int m0;
                int c0;
                m0 = n_main;
                c0 = n_cap;
                pulse(k);
                repeat (6) @(posedge clk);
                chk_cnt(n_main - m0, int'(c == k + 1));
                chk_cnt(n_cap - c0, int'(7 - c == k + 1));
            end
        end
        $display("test selectors done");
        wreg(itcsp_pkg::CSEL_IDX, 32'h1);
        for (int n = 0; n < 8; n++) begin
            logic [11:0] f;
            f = {3'(n + 3), 3'(n + 2), 3'(n + 1), 3'(n)};
            ladder(itcsp_pkg::MODE_8, 4'hF, f, f);
        end
        $display("test 8-bit ladder done");
        ladder(itcsp_pkg::MODE_16, 4'h5, {3'h0, 3'h5, 3'h0, 3'h3}, {3'h5, 3'h5, 3'h3, 3'h3});
        ladder(itcsp_pkg::MODE_16, 4'h5, {3'h0, 3'h1, 3'h0, 3'h6}, {3'h1, 3'h1, 3'h6, 3'h6});
        ladder(itcsp_pkg::MODE_32, 4'h1, 12'h002, {3'h2, 3'h2, 3'h2, 3'h2});
        $display("test chained modes done");
        wreg(itcsp_pkg::CTRL_IDX, 32'hCF);
        repeat (3) @(posedge clk);
        chk_reg({28'h0, clr}, 32'hF);
        apb(1'b0, itcsp_pkg::CTRL_IDX, 32'h0, rd, er);
        chk_reg(rd, 32'hCF);
        apb(1'b0, itcsp_pkg::STAT_IDX, 32'h0, rd, er);
        chk_reg(rd, 32'h0);
        wreg(itcsp_pkg::CTRL_IDX, 32'h0);
        $display("test prohibited mode done");
        test_done();
    end
endmodule
`default_nettype wire
